/* src/float_abs_map.vh */
// Constants for the floating-point absolute value unit.
`ifndef FLOAT_ABS_MAP_VH
`define FLOAT_ABS_MAP_VH
`define FLOAT_ABS_WORD_WIDTH   16
`define FLOAT_ABS_ADDR_WIDTH   16
`define FLOAT_ABS_SIGN_BIT     15
`define FLOAT_ABS_INDEX_COUNT  12
`define FLOAT_ABS_INDEX_V      4'h0
`define FLOAT_ABS_INDEX_Z      4'h1
`define FLOAT_ABS_INDEX_P0     4'h2
`endif

/* src/float_abs_trigger.v */
// Enable qualifier: level or rising-edge form of the operation trigger.
`timescale 1ns/1ps
module float_abs_trigger (
    // Clock and reset
    input  wire clock,
    input  wire rst,
    // Control
    input  wire enable,
    input  wire pulseMode,
    output reg  fire
);
    reg enablePrev;
    // ==========================================
    // Trigger
    always @(posedge clock) begin
        if (rst) begin
            enablePrev <= 1'b0;
            fire       <= 1'b0;
        end else begin
            enablePrev <= enable;
            fire       <= pulseMode ? (enable & ~enablePrev) : enable;
        end
    end
endmodule // float_abs_trigger

/* src/float_absolute_op.v */
// Floating-point absolute value unit working in place on a register pair.
// Overview of operation
// - Operand is an IEEE-754 single-precision value in two 16-bit registers.
// - Operate every scan while enable is 1, or on its rising edge in pulse form.
// - Absolute value is written back into the same register pair.
// - Target may be offset by index register V, Z or P0 through P9.
`timescale 1ns/1ps
`include "float_abs_map.vh"
module float_absolute_op #(
    parameter WORD_WIDTH = `FLOAT_ABS_WORD_WIDTH,
    parameter ADDR_WIDTH = `FLOAT_ABS_ADDR_WIDTH
) (
    // Clock and reset
    input  wire                  clock,
    input  wire                  rst,
    // Operation control
    input  wire                  enable,
    input  wire                  pulseMode,
    input  wire [ADDR_WIDTH-1:0] targetAddr,
    input  wire                  useIndex,
    input  wire [3:0]            indexSel,
    input  wire [ADDR_WIDTH*`FLOAT_ABS_INDEX_COUNT-1:0] pointer_index_regs,
    // Register memory port
    output reg  [ADDR_WIDTH-1:0] memAddr,
    output reg                   memRead,
    output reg                   memWrite,
    output reg  [WORD_WIDTH-1:0] memWriteData,
    input  wire [WORD_WIDTH-1:0] memReadData,
    // Status
    output reg                   busy,
    output reg                   done,
    output reg                   oddAddrError
);
    // ==========================================
    // State encoding and constants
    localparam [1:0]            ST_IDLE     = 2'h0;
    localparam [1:0]            ST_READ_HI  = 2'h1;
    localparam [1:0]            ST_WRITE_HI = 2'h2;
    localparam [WORD_WIDTH-1:0] SIGN_MASK   = {{(WORD_WIDTH-1){1'b0}}, 1'b1} << `FLOAT_ABS_SIGN_BIT;

    // ==========================================
    // Registered state and its next values
    reg  [1:0]            state;
    reg  [1:0]            next_state;
    reg  [ADDR_WIDTH-1:0] pairAddr;
    reg  [ADDR_WIDTH-1:0] next_pairAddr;
    reg  [ADDR_WIDTH-1:0] next_memAddr;
    reg                   next_memRead;
    reg                   next_memWrite;
    reg  [WORD_WIDTH-1:0] next_memWriteData;
    reg                   next_busy;
    reg                   next_done;
    reg                   next_oddAddrError;

    // ==========================================
    // Decoded conditions
    wire                  fire;
    wire [ADDR_WIDTH-1:0] indexOffset;
    wire [ADDR_WIDTH-1:0] effAddr;
    wire [ADDR_WIDTH-1:0] startHigh;
    wire [ADDR_WIDTH-1:0] highAddr;
    wire [WORD_WIDTH-1:0] absHigh;
    wire                  takeGood;
    wire                  takeOdd;

    // Picks one index register; indices beyond the set read as zero offset.
    function [ADDR_WIDTH-1:0] pickIndex;
        input [ADDR_WIDTH*`FLOAT_ABS_INDEX_COUNT-1:0] regs;
        input [3:0]                              sel;
        integer i;
        begin
            pickIndex = {ADDR_WIDTH{1'b0}};
            for (i = 0; i < `FLOAT_ABS_INDEX_COUNT; i = i + 1) begin
                if (sel == i[3:0]) begin
                    pickIndex = regs[i*ADDR_WIDTH +: ADDR_WIDTH];
                end
            end
        end
    endfunction

    // ==========================================
    // Trigger
    float_abs_trigger u_trigger (
        .clock     (clock),
        .rst       (rst),
        .enable    (enable),
        .pulseMode (pulseMode),
        .fire      (fire)
    );

    // ==========================================
    // Address and result path
    assign indexOffset = useIndex ? pickIndex(pointer_index_regs, indexSel) : {ADDR_WIDTH{1'b0}};
    assign effAddr     = targetAddr + indexOffset;
    assign startHigh   = effAddr + {{(ADDR_WIDTH-1){1'b0}}, 1'b1};
    assign highAddr    = pairAddr + {{(ADDR_WIDTH-1){1'b0}}, 1'b1};
    // Only the high word carries the sign, so the low word is never touched.
    assign absHigh     = memReadData & ~SIGN_MASK;
    // An odd pair address is refused rather than corrupting the neighbouring pair.
    assign takeGood    = (state == ST_IDLE) && fire && !effAddr[0];
    assign takeOdd     = (state == ST_IDLE) && fire && effAddr[0];

    // ==========================================
    // Next state
    always @* begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (takeGood) begin
                    next_state = ST_READ_HI;
                end
            end
            ST_READ_HI: begin
                // Read data stands one cycle after the strobe.
                next_state = ST_WRITE_HI;
            end
            ST_WRITE_HI: begin
                next_state = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // ==========================================
    // Next address and write data
    always @* begin
        next_pairAddr     = pairAddr;
        next_memAddr      = memAddr;
        next_memWriteData = memWriteData;
        case (state)
            ST_IDLE: begin
                if (takeGood) begin
                    next_pairAddr = effAddr;
                    next_memAddr  = startHigh;
                end
            end
            ST_WRITE_HI: begin
                next_memAddr      = highAddr;
                next_memWriteData = absHigh;
            end
            default: begin
                next_memAddr = memAddr;
            end
        endcase
    end

    // ==========================================
    // Next strobes
    always @* begin
        next_memRead  = 1'b0;
        next_memWrite = 1'b0;
        next_done     = 1'b0;
        case (state)
            ST_IDLE: begin
                next_memRead = takeGood;
            end
            ST_WRITE_HI: begin
                next_memWrite = 1'b1;
                next_done     = 1'b1;
            end
            default: begin
                next_memRead = 1'b0;
            end
        endcase
    end

    // ==========================================
    // Next status
    // Triggers that arrive while busy are dropped, since an operation cannot be queued.
    always @* begin
        next_busy         = busy;
        next_oddAddrError = oddAddrError;
        case (state)
            ST_IDLE: begin
                next_busy = takeGood;
                if (takeOdd) begin
                    next_oddAddrError = 1'b1;
                end else if (takeGood) begin
                    next_oddAddrError = 1'b0;
                end
            end
            ST_WRITE_HI: begin
                next_busy = 1'b0;
            end
            default: begin
                next_busy = busy;
            end
        endcase
    end

    // ==========================================
    // Registers
    // Every output is a flip-flop, so the memory sees clean strobes.
    always @(posedge clock) begin
        if (rst) begin
            state        <= ST_IDLE;
            pairAddr     <= {ADDR_WIDTH{1'b0}};
            memAddr      <= {ADDR_WIDTH{1'b0}};
            memRead      <= 1'b0;
            memWrite     <= 1'b0;
            memWriteData <= {WORD_WIDTH{1'b0}};
            busy         <= 1'b0;
            done         <= 1'b0;
            oddAddrError <= 1'b0;
        end else begin
            state        <= next_state;
            pairAddr     <= next_pairAddr;
            memAddr      <= next_memAddr;
            memRead      <= next_memRead;
            memWrite     <= next_memWrite;
            memWriteData <= next_memWriteData;
            busy         <= next_busy;
            done         <= next_done;
            oddAddrError <= next_oddAddrError;
        end
    end
endmodule // float_absolute_op

/* testbench/float_abs_monitor.sv */
// Assertion checker for the floating-point absolute value unit.
`timescale 1ns/1ps
module float_abs_monitor (
    input wire        clock, rst, enable, memRead, memWrite, done, busy, oddAddrError,
    input wire [15:0] memAddr, memWriteData, memReadData
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    chk_read_enabled: assert property (memRead |-> $past(enable, 2)) else $error("read without enable");
    chk_write_timing: assert property (memRead |=> !memWrite ##1 (memWrite && done)) else $error("write late");
    chk_same_pair: assert property (memWrite |-> $past(memRead, 2) && memAddr == $past(memAddr, 2))
        else $error("write to other word");
    chk_sign_clear: assert property (memWrite |-> memWriteData == ($past(memReadData) & 16'h7FFF))
        else $error("bad result");
    chk_odd_high: assert property (memRead |-> memAddr[0]) else $error("pair base odd");
    chk_busy_span: assert property (memRead |-> busy ##1 busy ##1 !busy) else $error("busy span wrong");
    chk_odd_quiet: assert property ($rose(oddAddrError) |-> !memRead && !busy) else $error("odd pair accessed");
    cover property (memRead ##2 memWrite);
    cover property (enable ##1 !enable);
    cover property (memWrite ##3 memWrite);
    cover property ($rose(oddAddrError));
endmodule // float_abs_monitor
bind float_absolute_op float_abs_monitor i_float_abs_monitor (.clock, .rst, .enable, .memRead, .memWrite, .done,
    .busy, .oddAddrError,
    .memAddr, .memWriteData, .memReadData);

/* testbench/testbench.sv */
// Self-checking bench for the floating-point absolute value unit.
`timescale 1ns/1ps
module testbench;
    reg         clock = 0, rst = 1, enable = 0, pulseMode = 0, useIndex = 0;
    reg [3:0]   indexSel = 4'h0;
    reg [15:0]  targetAddr = 16'h0, memReadData = 16'h0, mem [0:15];
    // Index registers from the bottom: V = 2, Z = 6, P0 = 4, P9 = 8; the rest read zero.
    reg [191:0] pir = {16'h0008, 128'h0, 16'h0004, 16'h0006, 16'h0002};
    wire [15:0] memAddr, memWriteData;
    wire        memRead, memWrite, busy, done, oddAddrError;
    integer     fails = 0, n_compared = 0, nw = 0, k;
    always #25 clock = ~clock;
    float_absolute_op i_float_absolute_op (.clock(clock), .rst(rst), .enable(enable), .pulseMode(pulseMode),
        .targetAddr(targetAddr), .useIndex(useIndex), .indexSel(indexSel), .pointer_index_regs(pir), .memAddr(memAddr),
        .memRead(memRead), .memWrite(memWrite), .memWriteData(memWriteData), .memReadData(memReadData),
        .busy(busy), .done(done), .oddAddrError(oddAddrError));
    // Idle read data is inverted each cycle so a late sample never looks valid.
    always @(posedge clock) begin
        memReadData <= #1 memRead ? mem[memAddr[3:0]] : ~memReadData;
        if (memWrite) mem[memAddr[3:0]] <= memWriteData;
        if (memWrite) nw <= nw + 1;
    end
    task check(input [15:0] seen, input [15:0] exp);
        begin
            n_compared = n_compared + 1;
            if (seen !== exp) begin
                fails = fails + 1;
                $display("ERROR %0t saw %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task run(input [15:0] t, input u, input [3:0] s, input pm, input integer n);
        begin
            @(posedge clock);
            #1 targetAddr = t;
            useIndex = u;
            indexSel = s;
            pulseMode = pm;
            enable = 1;
            k = nw;
            repeat (n) @(posedge clock);
            #1 enable = 0;
            repeat (6) @(posedge clock);
        end
    endtask
    task test_pulse;
        begin
            mem[9] = 16'hC2C8;
            mem[8] = 16'h8000;
            run(16'h8, 0, 4'h0, 1, 10);
            check(nw - k, 16'h1);
            check(mem[9], 16'h42C8);
            check(mem[8], 16'h8000);
            check(busy, 16'h0);
            check(oddAddrError, 16'h0);
            $display("pulse test done");
        end
    endtask
    task test_level;
        begin
            mem[9] = 16'hC2C8;
            run(16'h8, 0, 4'h0, 0, 9);
            check(nw - k, 16'h3);
            check(mem[9], 16'h42C8);
            $display("level test done");
        end
    endtask
    task test_index;
        begin
            mem[9] = 16'hBF80;
            mem[13] = 16'hC120;
            mem[11] = 16'hC000;
            mem[15] = 16'h8001;
            mem[7] = 16'hFFFF;
            run(16'h6, 1, 4'h0, 1, 3);
            check(mem[9], 16'h3F80);
            run(16'h6, 1, 4'h1, 1, 3);
            check(mem[13], 16'h4120);
            run(16'h6, 1, 4'h2, 1, 3);
            check(mem[11], 16'h4000);
            run(16'h6, 1, 4'hB, 1, 3);
            check(mem[15], 16'h0001);
            run(16'h6, 1, 4'hF, 1, 3);
            check(mem[7], 16'h7FFF);
            $display("index test done");
        end
    endtask
    task test_odd;
        begin
            run(16'h7, 0, 4'h0, 1, 3);
            check(oddAddrError, 16'h1);
            check(nw - k, 16'h0);
            run(16'h8, 0, 4'h0, 1, 3);
            check(oddAddrError, 16'h0);
            check(nw - k, 16'h1);
            check(mem[9], 16'h3F80);
            $display("odd address test done");
        end
    endtask
    task final_report;
        begin
            $display("compared %0d failed %0d", n_compared, fails);
            if (fails == 0 && n_compared > 0) $display("bench passed");
            else $display("bench failed");
            $finish;
        end
    endtask
    initial begin
        repeat (5) @(posedge clock);
        #1 rst = 0;
        test_pulse;
        test_level;
        test_index;
        test_odd;
        final_report;
    end
    initial begin
        #20000 fails = fails + 1;
        final_report;
    end
endmodule // testbench
